// File: hw/scmc_params.svh
`ifndef SCMC_PARAMS_SVH
`define SCMC_PARAMS_SVH
// ----------------------------------------
// register map and field layout
// ----------------------------------------
`define SCMC_CTL_OFS 4'h0
`define SCMC_STAT_OFS 4'h4
`define SCMC_CTL_RESET 8'h03
`define SCMC_CTL_WMASK 8'hF3
`define SCMC_DIV_MSB 7
`define SCMC_DIV_LSB 5
`define SCMC_FAST_BIT 4
`define SCMC_LRDY_BIT 3
`define SCMC_HRDY_BIT 2
`define SCMC_IDLE_BIT 1
`define SCMC_HSEL_BIT 0
// ----------------------------------------
// oscillator settle counts, in oscillator cycles, then log2 ratios of the peripheral taps
// ----------------------------------------
`define SCMC_HXT_READY 10'h200
`define SCMC_HIGH_RC_OSC_READY 10'h010
`define SCMC_LXT_READY 10'h080
`define SCMC_LOW_RC_OSC_READY 10'h002
`define SCMC_PDIV16_LOG 3'h4
`define SCMC_PDIV64_LOG 3'h6
`endif

// File: hw/scmc_pkg.sv
package scmc_pkg;
    // ----------------------------------------
    // operating states
    // ----------------------------------------
    typedef enum logic [2:0] {
        SCMC_RUN = 3'h0,
        SCMC_IDLE_RUN = 3'h1,
        SCMC_IDLE_STOP = 3'h2,
        SCMC_SLEEP_SUB = 3'h3,
        SCMC_SLEEP_DEEP = 3'h4,
        SCMC_WAKE = 3'h5,
        SCMC_FAST = 3'h6
    } scmc_mode_t;

    // ----------------------------------------
    // whole state of the top module
    // ----------------------------------------
    typedef struct packed {
        scmc_mode_t mode;
        logic [7:0] ctl;
        logic [3:0] cur;
        logic [5:0] div_cnt;
        logic fast_live;
        logic sys_en;
        logic d16;
        logic d64;
        logic cpu;
        logic hon;
        logic lon;
        logic wait_n;
        logic [31:0] rdata;
    } scmc_st_t;
endpackage

// File: hw/scmc_osc_tick.sv
module scmc_osc_tick import scmc_pkg::*; #(
    parameter int CW = 10
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic osc_pin,
    input wire logic osc_on,
    input wire logic [CW-1:0] ready_target,
    output logic tick,
    output logic ready
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [CW-1:0] cnt;
        logic rdy;
    } scmc_tick_st_t;

    scmc_tick_st_t st_q;
    scmc_tick_st_t st_d;

    // edge seen only after the second stage; gated so a stopped osc gives nothing
    assign tick = st_q.s2 & ~st_q.s3 & osc_on;
    assign ready = st_q.rdy;

    // ----------------------------------------
    // sync, edge detect and settle counter
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = osc_pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (!osc_on)
        begin
            st_d.cnt = '0;
            st_d.rdy = 1'b0;
        end
        else if (tick && !st_q.rdy)
        begin
            st_d.cnt = CW'(st_q.cnt + 1'b1);
            st_d.rdy = (CW'(st_q.cnt + 1'b1) == ready_target);
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule // scmc_osc_tick

// File: hw/scmc_top.sv
// What this block does
// - divider field picks substitute or divided clock
// - high select bit gives undivided high clock
// - high oscillator stops when substitute selected
// - sixteen and sixtyfour taps stop too
// - fast wakeup only with high crystal
// - low ready low in deep sleep
// - high ready follows high oscillator settling
// - halt picks idle or sleep state
// - fast wakeup never from deep sleep
// - fast wakeup runs substitute until ready
// - high rc oscillator ignores fast wakeup bit
// - watchdog and voltage detect both off means deep sleep, no fast wakeup
// - slow applied only when low ready
// - voltage detect forbids deep sleep
// - back to high on codes 010-111
`include "scmc_params.svh"
module scmc_top import scmc_pkg::*; (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic high_osc_pin,
    input wire logic low_osc_pin,
    input wire logic high_osc_is_crystal,
    input wire logic low_osc_is_crystal,
    input wire logic watchdog_enable,
    input wire logic voltage_detect_enable,
    input wire logic idle_keep_system_clock,
    input wire logic halt_req,
    input wire logic wake_req,
    output logic high_osc_enable,
    output logic low_osc_enable,
    output logic sys_clk_en,
    output logic periph_div16_en,
    output logic periph_div64_en,
    output logic cpu_run
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // selection {high_clock_select, clock_divider_select} runs off high clock?
    function automatic logic src_high(input logic [3:0] s);
        src_high = s[3] | s[2] | s[1];
    endfunction

    // log2 of division ratio for a selection
    function automatic logic [2:0] ratio_log(input logic [3:0] s);
        logic [2:0] r;
        r = 3'h6; // code 010: over 64
        if (s[3])
            r = 3'h0;
        else
        begin
            unique case (s[2:0])
                3'h7: r = 3'h1;
                3'h6: r = 3'h2;
                3'h5: r = 3'h3;
                3'h4: r = 3'h4;
                3'h3: r = 3'h5;
                default: r = 3'h6;
            endcase
        end
        ratio_log = r;
    endfunction

    // divider counter reaches the end of a 2**n period
    function automatic logic div_hit(input logic [5:0] cnt, input logic [2:0] n);
        logic [5:0] mask;
        mask = 6'h3F >> (3'h6 - n);
        div_hit = ((cnt & mask) == mask);
    endfunction

    // whole block state and its next value
    scmc_st_t st_q;
    scmc_st_t st_d;
    logic htick;
    logic ltick;
    logic hrdy;
    logic lrdy;
    logic [3:0] want;
    logic cur_ready;
    logic want_ready;
    logic sys_tick;
    logic fast_ok;
    logic req;

    // ----------------------------------------
    // oscillator inputs
    // ----------------------------------------
    // high osc, counted on synced rising edges
    scmc_osc_tick #(.CW(10)) u_high (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .osc_pin(high_osc_pin),
        .osc_on(st_q.hon),
        .ready_target(high_osc_is_crystal ? `SCMC_HXT_READY : `SCMC_HIGH_RC_OSC_READY),
        .tick(htick),
        .ready(hrdy)
    );

    // low osc doubles as the substitute clock
    scmc_osc_tick #(.CW(10)) u_low (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .osc_pin(low_osc_pin),
        .osc_on(st_q.lon),
        .ready_target(low_osc_is_crystal ? `SCMC_LXT_READY : `SCMC_LOW_RC_OSC_READY),
        .tick(ltick),
        .ready(lrdy)
    );

    // ----------------------------------------
    // source selection terms
    // ----------------------------------------
    // wanted selection from software, next to the one applied
    assign want = {st_q.ctl[`SCMC_HSEL_BIT], st_q.ctl[`SCMC_DIV_MSB:`SCMC_DIV_LSB]};
    assign cur_ready = src_high(st_q.cur) ? hrdy : lrdy;
    assign want_ready = src_high(want) ? hrdy : lrdy;
    // one system pulse from the source now in use
    assign sys_tick = src_high(st_q.cur) ? (htick & div_hit(st_q.div_cnt, ratio_log(st_q.cur))) : ltick;
    // substitute as stand-in is only worth it for a slow-settling crystal
    assign fast_ok = st_q.ctl[`SCMC_FAST_BIT] & high_osc_is_crystal & src_high(st_q.cur);
    // one strobe term; read and write never stand together
    assign req = avs_read | avs_write;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        // divider runs on high ticks only, and clears to zero while the osc is off
        if (!st_q.hon)
            st_d.div_cnt = 6'h00;
        else if (htick)
            st_d.div_cnt = 6'(st_q.div_cnt + 1'b1);

        // operating state machine
        unique case (st_q.mode)
            SCMC_RUN:
            begin
                if (halt_req)
                begin
                    if (st_q.ctl[`SCMC_IDLE_BIT])
                        st_d.mode = idle_keep_system_clock ? SCMC_IDLE_RUN : SCMC_IDLE_STOP;
                    else if (voltage_detect_enable || watchdog_enable)
                        st_d.mode = SCMC_SLEEP_SUB;
                    else
                        st_d.mode = SCMC_SLEEP_DEEP;
                end
                // switch after a whole pulse of the old source, or at once if it is not ready; new one settled
                else if (want != st_q.cur && want_ready && (sys_tick || !cur_ready))
                    st_d.cur = want;
            end
            // clock kept running, only the cpu is parked
            SCMC_IDLE_RUN:
            begin
                if (wake_req)
                    st_d.mode = SCMC_RUN;
            end
            // both keep the substitute, so a fast wake is possible
            SCMC_IDLE_STOP, SCMC_SLEEP_SUB:
            begin
                if (wake_req)
                begin
                    st_d.mode = fast_ok ? SCMC_FAST : SCMC_WAKE;
                    st_d.fast_live = 1'b0;
                end
            end
            // substitute is off here; full settle wait only
            SCMC_SLEEP_DEEP:
            begin
                if (wake_req)
                    st_d.mode = SCMC_WAKE; // substitute is stopped here
            end
            // hold the cpu until the applied source has settled
            SCMC_WAKE:
            begin
                if (cur_ready)
                    st_d.mode = SCMC_RUN;
            end
            // stand-in run on the substitute; cpu starts at its first edge
            SCMC_FAST:
            begin
                if (ltick)
                    st_d.fast_live = 1'b1;
                if (hrdy)
                begin
                    st_d.mode = SCMC_RUN;
                    st_d.fast_live = 1'b0;
                end
            end
            // unused code falls back to a safe settle wait
            default:
                st_d.mode = SCMC_WAKE;
        endcase

        // oscillator enables
        st_d.hon = (st_d.mode == SCMC_RUN || st_d.mode == SCMC_IDLE_RUN || st_d.mode == SCMC_WAKE
                    || st_d.mode == SCMC_FAST) && (src_high(st_d.cur) || src_high(want));
        st_d.lon = (st_d.mode != SCMC_SLEEP_DEEP);

        // clock enables toward cpu and peripherals
        st_d.sys_en = ((st_q.mode == SCMC_RUN || st_q.mode == SCMC_IDLE_RUN) && sys_tick && cur_ready)
                      || (st_q.mode == SCMC_FAST && ltick);
        st_d.d16 = htick & div_hit(st_q.div_cnt, `SCMC_PDIV16_LOG);
        st_d.d64 = htick & div_hit(st_q.div_cnt, `SCMC_PDIV64_LOG);
        st_d.cpu = (st_d.mode == SCMC_RUN) || (st_d.mode == SCMC_FAST && st_d.fast_live);

        // avalon slave: answer one cycle after the request shows
        if (req && st_q.wait_n)
        begin
            st_d.wait_n = 1'b0;
            if (avs_address == `SCMC_CTL_OFS)
                st_d.rdata = {24'h000000, st_q.ctl[7:4], lrdy, hrdy, st_q.ctl[1:0]};
            else if (avs_address == `SCMC_STAT_OFS)
                st_d.rdata = {24'h000000, st_q.cur, st_q.cpu, st_q.mode};
            else
                st_d.rdata = 32'h00000000;
        end
        else
        begin
            st_d.wait_n = 1'b1;
            // ready bits are live flags; writes to them are dropped
            if (avs_write && !st_q.wait_n && avs_address == `SCMC_CTL_OFS)
                st_d.ctl = avs_writedata[7:0] & `SCMC_CTL_WMASK;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
            st_q.mode <= SCMC_WAKE; // cpu held until high osc settles
            st_q.ctl <= `SCMC_CTL_RESET & `SCMC_CTL_WMASK;
            st_q.cur <= 4'h8;
            st_q.hon <= 1'b1;
            st_q.lon <= 1'b1;
            st_q.wait_n <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // outputs straight from the state register
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.wait_n;
    assign high_osc_enable = st_q.hon;
    assign low_osc_enable = st_q.lon;
    assign sys_clk_en = st_q.sys_en;
    assign periph_div16_en = st_q.d16;
    assign periph_div64_en = st_q.d64;
    assign cpu_run = st_q.cpu;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // all checks run on the one clock, quiet during reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    high_stop_slow_a: assert property (st_q.mode == SCMC_RUN && !src_high(st_q.cur) && !src_high(want)
        |=> !high_osc_enable) else $error("high osc left running in slow");
    tap_stop_a: assert property (!high_osc_enable |=> !periph_div16_en && !periph_div64_en)
        else $error("peripheral tap pulsed with high osc off");
    halt_sleep_a: assert property (st_q.mode == SCMC_RUN && halt_req && !st_q.ctl[1] && !voltage_detect_enable
        && !watchdog_enable |=> st_q.mode == SCMC_SLEEP_DEEP ##1 !low_osc_enable)
        else $error("halt did not reach deep sleep");
    vdet_block_a: assert property (st_q.mode == SCMC_RUN && halt_req && !st_q.ctl[1] && voltage_detect_enable
        |=> st_q.mode == SCMC_SLEEP_SUB) else $error("deep sleep despite voltage detect");
    deep_low_a: assert property (st_q.mode == SCMC_SLEEP_DEEP ##1 st_q.mode == SCMC_SLEEP_DEEP
        |-> !lrdy && !cpu_run && !sys_clk_en) else $error("low ready in deep sleep");
    high_rdy_off_a: assert property (!high_osc_enable |=> !hrdy) else $error("high ready with osc off");
    fast_enter_a: assert property ((st_q.mode == SCMC_SLEEP_SUB || st_q.mode == SCMC_IDLE_STOP) && wake_req
        && fast_ok |=> st_q.mode == SCMC_FAST ##0 !cpu_run) else $error("fast wake not taken");
    rc_no_fast_a: assert property ((st_q.mode == SCMC_SLEEP_SUB || st_q.mode == SCMC_SLEEP_DEEP) && wake_req
        && !high_osc_is_crystal |=> st_q.mode == SCMC_WAKE) else $error("rc wake used fast path");
    deep_no_fast_a: assert property (st_q.mode == SCMC_SLEEP_DEEP && wake_req |=> st_q.mode != SCMC_FAST)
        else $error("fast wake from deep sleep");
    clean_switch_a: assert property ($changed(st_q.cur) |-> $past(want_ready))
        else $error("source switched before ready");
    full_speed_a: assert property (st_q.mode == SCMC_RUN && st_q.cur[3] && htick && hrdy |=> sys_clk_en)
        else $error("undivided high pulse missed");
    bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

    // ----------------------------------------
    // mode, output, register and divider checks
    // ----------------------------------------
    // a stopped idle must give neither cpu nor system pulses
    idle_stop_quiet_a: assert property (st_q.mode == SCMC_IDLE_STOP ##1 st_q.mode == SCMC_IDLE_STOP
        |-> !sys_clk_en && !cpu_run) else $error("pulse seen in stopped idle");

    // the running idle keeps the clock but never the cpu
    idle_run_hold_a: assert property (st_q.mode == SCMC_IDLE_RUN |-> !cpu_run)
        else $error("cpu running in idle");

    // shallow sleep keeps the substitute alive for a fast wake
    sleep_sub_low_a: assert property (st_q.mode == SCMC_SLEEP_SUB |-> low_osc_enable)
        else $error("substitute stopped in shallow sleep");

    // stand-in run ends the cycle after the high osc settles
    fast_exit_a: assert property (st_q.mode == SCMC_FAST && hrdy |=> st_q.mode == SCMC_RUN)
        else $error("fast wake did not hand over");

    // cpu only executes in run or in the live stand-in phase
    cpu_mode_a: assert property (cpu_run |-> st_q.mode == SCMC_RUN || st_q.mode == SCMC_FAST)
        else $error("cpu running in a halted mode");

    // a high source in run must have its oscillator on
    high_on_run_a: assert property (st_q.mode == SCMC_RUN && src_high(st_q.cur) |-> high_osc_enable)
        else $error("high osc off while in use");

    // ready flags can never be stored by a write
    ready_ro_a: assert property (st_q.ctl[`SCMC_LRDY_BIT] == 1'b0 && st_q.ctl[`SCMC_HRDY_BIT] == 1'b0)
        else $error("ready flag held in control");

    // divider restarts from zero whenever the high osc stops
    div_rest_a: assert property (!high_osc_enable |=> st_q.div_cnt == 6'h00)
        else $error("divider ran with high osc off");

    // an idle bus never leaves waitrequest low
    bus_idle_a: assert property (!req |=> avs_waitrequest)
        else $error("answer without a request");

    fast_seen_c: cover property (st_q.mode == SCMC_FAST ##[1:1000] st_q.mode == SCMC_RUN);
    deep_seen_c: cover property (st_q.mode == SCMC_SLEEP_DEEP);
    slow_seen_c: cover property ($changed(st_q.cur) && !src_high(st_q.cur));
    idle_run_c: cover property (st_q.mode == SCMC_IDLE_RUN && sys_clk_en);
    // wake through the settle wait back to run
    wake_run_c: cover property (st_q.mode == SCMC_WAKE ##1 st_q.mode == SCMC_RUN);
endmodule // scmc_top

// File: tb/scmc_osc_model.sv
module scmc_osc_model #(
    parameter int HH = 12,
    parameter int HL = 40
) (
    input wire logic h_en,
    input wire logic l_en,
    output logic h_pin,
    output logic l_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // oscillators, flat at 0 while disabled
    // ----------------------------------------
    // a stopped oscillator must not leave stray edges for the settle counters
    initial
    begin
        h_pin = 1'b0;
        forever
        begin
            #HH h_pin = h_en ? ~h_pin : 1'b0;
        end
    end
    // low oscillator, much slower than the high one
    initial
    begin
        l_pin = 1'b0;
        forever
        begin
            #HL l_pin = l_en ? ~l_pin : 1'b0;
        end
    end
endmodule // scmc_osc_model

// File: tb/system_clock_mode_control_tb.sv
module system_clock_mode_control_tb;
    import scmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
    logic avs_waitrequest, hpin, lpin, hcry = 1'b1, lcry = 1'b1, wdt = 1'b0, vdet = 1'b0;
    logic keep = 1'b0, halt = 1'b0, wake = 1'b0, hen, len, sys_en, d16, d64, cpu_run;
    logic [15:0] lfsr = 16'h9B03;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    // ----------------------------------------
    // design, oscillators, clock, timeout
    // ----------------------------------------
    scmc_top uut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .high_osc_pin(hpin), .low_osc_pin(lpin),
        .high_osc_is_crystal(hcry), .low_osc_is_crystal(lcry), .watchdog_enable(wdt),
        .voltage_detect_enable(vdet), .idle_keep_system_clock(keep), .halt_req(halt), .wake_req(wake),
        .high_osc_enable(hen), .low_osc_enable(len), .sys_clk_en(sys_en), .periph_div16_en(d16),
        .periph_div64_en(d64), .cpu_run(cpu_run));
    scmc_osc_model osc (.h_en(hen), .l_en(len), .h_pin(hpin), .l_pin(lpin));
    // 4 ns clock
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    // a hang ends the run as a failure
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // system pulses per 64 high edges for a selection
    function automatic logic [31:0] ratio(input logic hs, input logic [2:0] c);
        return hs ? 32'h00000040 : 32'h00000040 >> (4'h8 - {1'b0, c});
    endfunction
    // one bus transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h000000, d};
        do
        begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // read until the masked byte matches, bounded
    task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, a, 8'h00);
            n++;
        end while ((rd[7:0] & m) !== v && n < 3000);
        chk("polled register", {24'h000000, v}, {24'h000000, rd[7:0] & m});
    endtask
    // counts pulses over a fixed window
    task automatic cnt(input int n, output int s16, output int sy);
        s16 = 0;
        sy = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            s16 += (d16 === 1'b1);
            sy += (sys_en === 1'b1);
        end
    endtask
    // system pulses between two divide-by-64 pulses
    task automatic cnt64(output int c, output int e);
        int k;
        k = 0;
        c = 0;
        e = 0;
        while (d64 !== 1'b1 && k < 3000)
        begin
            @(posedge ref_clk);
            k++;
        end
        do
        begin
            c += (sys_en === 1'b1);
            e += (d16 === 1'b1);
            @(posedge ref_clk);
            k++;
        end while (d64 !== 1'b1 && k < 6000);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        int i, a, b;
        logic [2:0] code, r;
        logic hs, idl, dp, fw;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(1'b0, 4'h0, 8'h00);
        chk("control after reset", 32'h00000003, rd & 32'h000000F3);
        poll(4'h0, 8'h0C, 8'h0C);
        poll(4'h4, 8'hFF, 8'h88);
        bus(1'b1, 4'h8, 8'hFF);
        bus(1'b0, 4'h8, 8'h00);
        chk("unmapped read", 32'h00000000, rd);
        // slow switch; the ready flags in the write must be dropped
        bus(1'b1, 4'h0, 8'h0C);
        poll(4'h4, 8'hF0, 8'h00);
        bus(1'b0, 4'h0, 8'h00);
        chk("low ready when slow", 32'h00000008, rd & 32'h0000000B);
        cnt(40, a, b);
        chk("high_osc_enable", 32'h00000000, {31'h0, hen});
        cnt(300, a, b);
        chk("div16 pulses", 32'h00000000, a);
        chk("slow clock runs", 32'h00000001, {31'h0, b > 0});
        // every divider code, random order and random side bits
        r = lfsr[2:0];
        for (i = 0; i < 9; i++)
        begin
            lfsr = nxt(lfsr);
            code = i[2:0] ^ r;
            hs = (i == 8);
            bus(1'b1, 4'h0, {code, lfsr[4], 2'b00, lfsr[5], hs});
            poll(4'h4, 8'hF0, {hs, code, 4'h0});
            if (hs || code > 3'h1)
            begin
                cnt64(a, b);
                chk("div16 per 64 edges", 32'h00000004, b);
                chk("pulses per 64 edges", ratio(hs, code), a);
            end
        end
        // halt kinds, then wake; case 5 uses a high rc oscillator
        for (i = 0; i < 6; i++)
        begin
            lfsr = nxt(lfsr);
            idl = (i < 2);
            dp = (i == 4);
            bus(1'b1, 4'h0, {lfsr[2:0], 3'h4, idl, 1'b1});
            poll(4'h4, 8'hFF, {1'b1, lfsr[2:0], 4'h8});
            @(posedge ref_clk);
            keep <= (i == 0);
            vdet <= (i == 2 || i == 5);
            wdt <= (i == 3);
            hcry <= (i != 5);
            @(posedge ref_clk);
            halt <= 1'b1;
            @(posedge ref_clk);
            halt <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chk("cpu_run on halt", 32'h00000000, {31'h0, cpu_run});
            bus(1'b0, 4'h4, 8'h00);
            chk("halt state", {29'h0, idl ? (i == 0 ? 3'h1 : 3'h2) : (dp ? 3'h4 : 3'h3)}, rd & 32'h7);
            cnt(100, a, b);
            chk("idle clock", {31'h0, i == 0}, {31'h0, b > 0});
            if (i != 0)
                poll(4'h0, 8'h04, 8'h00);
            if (dp)
            begin
                poll(4'h0, 8'h08, 8'h00);
                chk("low_osc_enable", 32'h00000000, {31'h0, len});
            end
            repeat (lfsr[9:4]) @(posedge ref_clk);
            wake <= 1'b1;
            @(posedge ref_clk);
            wake <= 1'b0;
            fw = (i != 0) && !dp && (i != 5);
            if (i != 0)
                poll(4'h4, 8'h0F, fw ? 8'h0E : 8'h05);
            poll(4'h4, 8'h0F, 8'h08);
            poll(4'h0, 8'h0C, 8'h0C);
        end
        give_verdict();
    end
endmodule // system_clock_mode_control_tb
